/* File: bench/ru_loader_model.sv */
// loader model: answers each load request of the sequencer with one done pulse
// assumes load_req_i stays high until done is seen; delay_i is at least one
// a request still high two edges after done is taken as the next load
`timescale 1ns/100ps
module ru_loader_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // bench control
    input wire logic [3:0] delay_i,
    input wire logic fail_i,
    input wire logic inj_crc_i,
    // loader side
    input wire logic load_req_i,
    output logic load_done_o,
    output logic crc_err_o
);
    logic [3:0] cnt_q;
    logic seen_q;
    logic bad_q;

    // ==========================================================
    // request to done
    // seen_q holds off until the sequencer has had time to drop or keep its request
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q <= 4'h0;
            seen_q <= 1'b0;
            bad_q <= 1'b0;
            load_done_o <= 1'b0;
        end
        else
        begin
            load_done_o <= 1'b0;
            bad_q <= 1'b0;
            if (!load_req_i)
            begin
                cnt_q <= 4'h0;
                seen_q <= 1'b0;
            end
            else if (seen_q)
            begin
                // a failed application load goes straight on to a factory load
                seen_q <= (cnt_q != 4'h1);
                cnt_q <= (cnt_q == 4'h1) ? 4'h0 : cnt_q + 4'h1;
            end
            else if (cnt_q >= delay_i)
            begin
                load_done_o <= 1'b1;
                bad_q <= fail_i;
                seen_q <= 1'b1;
                cnt_q <= 4'h0;
            end
            else
            begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // a failed load marks crc beside done; the bench may also inject a crc error
    assign crc_err_o = bad_q | inj_crc_i;
endmodule

/* File: bench/test_ru_image_sequencer.sv */
// testbench of the image sequencer, self-checking
// assumes the loader model answers every load request after a random delay
`timescale 1ns/100ps
module test_ru_image_sequencer
    import ru_seq_pkg::*;
;
    logic ref_clk, rst_b, wr, rd, par, err_low, pin_b, instr, done, crc, req;
    logic umode, amode, fail, inj;
    logic sclk, sdin, smode, supd, sdo;
    logic [34:0] sv, so;
    logic [3:0] addr, dly;
    logic [31:0] wdata, rdata, rv;
    logic [23:0] scan, boot, app_a, fact_a;
    int err_total, total_checks, seed, cyc;

    ru_image_sequencer i_ru_image_sequencer (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .scheme_parallel_i(par), .config_error_line_low_i(err_low),
        .reconfig_pin_b_i(pin_b), .upgrade_shift_clock_i(sclk), .shift_din_i(sdin),
        .shift_mode_i(smode), .shift_update_i(supd), .shift_dout_o(sdo),
        .set_factory_boot_address_instr_i(instr), .scan_boot_addr_i(scan),
        .load_done_i(done), .crc_err_i(crc), .load_req_o(req), .boot_addr_o(boot),
        .user_mode_o(umode), .app_mode_o(amode));

    ru_loader_model i_ru_loader_model (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
        .delay_i(dly), .fail_i(fail), .inj_crc_i(inj), .load_req_i(req),
        .load_done_o(done), .crc_err_o(crc));

    // ==========================================================
    // clock and hang guard
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // whole run is under a thousand cycles; the ceiling leaves wide margin
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            err_total = err_total + 1;
            end_sim();
        end
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] st(input logic fa, input int b);
        return (32'(fa) << 4) | (32'h1 << b);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // wait for a load, check its address, let the model finish it
    task automatic go_load(input logic [23:0] b, input logic app);
        int n;
        logic [31:0] r;
        r = $random(seed);
        dly <= {1'b0, r[2:0]} + 4'h1;
        n = 0;
        while (req !== 1'b1 && n < 80)
        begin
            @(posedge ref_clk);
            #1;
            n = n + 1;
        end
        chk({8'h00, boot}, {8'h00, b});
        while (umode !== 1'b1 && n < 160)
        begin
            @(posedge ref_clk);
            #1;
            n = n + 1;
        end
        chk({30'h0, umode, amode}, {30'h0, 1'b1, app});
    endtask

    // one-cycle cause: 0 pin, 1 error line, 2 internal crc
    task automatic fire(input int k);
        @(posedge ref_clk);
        pin_b <= (k != 0);
        err_low <= (k == 1);
        inj <= (k == 2);
        @(posedge ref_clk);
        pin_b <= 1'b1;
        err_low <= 1'b0;
        inj <= 1'b0;
    endtask

    // one slow shift-clock step per bit; dout is read once the previous step settled
    task automatic shift_bits(input logic m, input int n, input logic [34:0] v,
                              output logic [34:0] o);
        o = '0;
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            sclk <= 1'b0;
            smode <= m;
            sdin <= v[i];
            repeat (4) @(posedge ref_clk);
            #1;
            o[i] = sdo;
            @(posedge ref_clk);
            sclk <= 1'b1;
        end
    endtask

    task automatic end_sim();
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        {err_total, total_checks, cyc} = '0;
        seed = 60;
        {rst_b, wr, rd, par, err_low, instr, fail, inj} = '0;
        {sclk, sdin, smode, supd} = '0;
        {addr, wdata, scan} = '0;
        pin_b = 1'b1;
        dly = 4'h1;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        go_load(FACTORY_ADDR_SERIAL, 1'b0);
        rd_reg(REG_CTRL_WD, rv);
        chk(rv, 32'h00001000);
        rd_reg(REG_STATE, rv);
        chk(rv, 32'h00000004);
        rd_reg(4'hF, rv);
        chk(rv, 32'h0);
        wr_reg(REG_CTRL_ADDR, 32'h00FFFFFC);
        rd_reg(REG_CTRL_ADDR, rv);
        chk(rv, 32'h0);
        // shift path: load the update register serially, then capture it back out
        rv = $random(seed);
        sv = {rv[2:0], rv};
        shift_bits(1'b1, 35, sv, so);
        repeat (4) @(posedge ref_clk);
        supd <= 1'b1;
        @(posedge ref_clk);
        supd <= 1'b0;
        rd_reg(REG_UPD_ADDR, rv);
        chk(rv, {8'h00, sv[21:0], 2'b00});
        rd_reg(REG_UPD_WD, rv);
        chk(rv, {19'h0, sv[34], sv[33:22]});
        shift_bits(1'b0, 1, '0, so);
        shift_bits(1'b1, 35, '0, so);
        chk(32'(so), sv[31:0]);
        chk(32'(so[34:32]), 32'(sv[34:32]));
        rv = $random(seed);
        // application images sit away from both factory addresses
        app_a = {rv[23:16] | 8'h02, 16'h0000};
        wr_reg(REG_UPD_ADDR, {8'h00, app_a});
        // causes from a running application: pin, error line, crc
        for (int k = 0; k < 3; k++)
        begin
            wr_reg(REG_UPD_WD, 32'h0);
            wr_reg(REG_CMD, 32'h1);
            go_load(app_a, 1'b1);
            if (k == 0)
            begin
                rd_reg(REG_STATUS, rv);
                chk(rv, st(1'b0, 0));
                rd_reg(REG_CTRL_ADDR, rv);
                chk(rv, {8'h00, app_a});
            end
            // staging is refused in an application, so app_a must stay
            wr_reg(REG_UPD_ADDR, 32'h00AB0000);
            fire(k);
            go_load(FACTORY_ADDR_SERIAL, 1'b0);
            rd_reg(REG_STATUS, rv);
            chk(rv, st(1'b1, k));
        end
        // watchdog at timer zero: expires on the ninth tick of five cycles after a kick
        wr_reg(REG_UPD_WD, 32'h00001000);
        wr_reg(REG_CMD, 32'h1);
        go_load(app_a, 1'b1);
        repeat (5)
        begin
            repeat (20) @(posedge ref_clk);
            wr_reg(REG_CMD, 32'h2);
        end
        repeat (28) @(posedge ref_clk);
        #1;
        chk({31'h0, amode}, 32'h1);
        go_load(FACTORY_ADDR_SERIAL, 1'b0);
        rd_reg(REG_STATUS, rv);
        chk(rv, st(1'b1, 3));
        // failed application load falls back to the factory image
        @(posedge ref_clk);
        fail <= 1'b1;
        wr_reg(REG_CMD, 32'h1);
        for (int n = 0; n < 80 && done !== 1'b1; n++)
        begin
            @(posedge ref_clk);
            #1;
        end
        @(posedge ref_clk);
        fail <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        go_load(FACTORY_ADDR_SERIAL, 1'b0);
        rd_reg(REG_STATUS, rv);
        chk(rv, st(1'b1, 2));
        // second reset with the parallel strap, then a new factory address
        @(posedge ref_clk);
        rst_b <= 1'b0;
        par <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        go_load(FACTORY_ADDR_PARALLEL, 1'b0);
        rv = $random(seed);
        fact_a = {~app_a[23:16], rv[15:0]};
        @(posedge ref_clk);
        instr <= 1'b1;
        scan <= fact_a;
        @(posedge ref_clk);
        instr <= 1'b0;
        rd_reg(REG_FACT_ADDR, rv);
        chk(rv, {8'h00, fact_a});
        wr_reg(REG_UPD_ADDR, {8'h00, app_a});
        wr_reg(REG_UPD_WD, 32'h0);
        wr_reg(REG_CMD, 32'h1);
        go_load(app_a, 1'b1);
        fire(0);
        go_load(fact_a, 1'b0);
        // a fabric request from the application must act like the pin
        wr_reg(REG_CMD, 32'h1);
        go_load(app_a, 1'b1);
        wr_reg(REG_CMD, 32'h1);
        go_load(fact_a, 1'b0);
        rd_reg(REG_STATUS, rv);
        chk(rv, st(1'b1, 0));
        end_sim();
    end
endmodule

/* File: hdl/ru_image_sequencer.sv */
// image sequencer: picks factory or application image, records why it reloaded
// assumes load_done_i and crc_err_i come from the loader on ref_clk_i
`timescale 1ns/100ps
module ru_image_sequencer
    import ru_seq_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // device pins
    input wire logic scheme_parallel_i,
    input wire logic config_error_line_low_i,
    input wire logic reconfig_pin_b_i,
    input wire logic upgrade_shift_clock_i,
    input wire logic shift_din_i,
    input wire logic shift_mode_i,
    input wire logic shift_update_i,
    output logic shift_dout_o,
    // boundary-scan instruction
    input wire logic set_factory_boot_address_instr_i,
    input wire logic [BOOT_W-1:0] scan_boot_addr_i,
    // configuration loader
    input wire logic load_done_i,
    input wire logic crc_err_i,
    output logic load_req_o,
    output logic [BOOT_W-1:0] boot_addr_o,
    output logic user_mode_o,
    output logic app_mode_o
);

    seq_state_e state_q;
    ctrl_s ctrl_q, upd_q;
    status_s status_q, cause;
    logic [BOOT_W-1:0] factory_addr_q;
    logic parallel_q;
    logic [1:0] wait_q;
    logic [5:0] sync1_q, sync2_q;
    logic shclk_prev_q, rcfg_prev_q;
    logic [SHIFT_W-1:0] shift_q;
    logic [2:0] osc_cnt_q;
    logic osc_tick_q, wd_expired, wd_kick, fabric_rcfg, pin_rcfg, shift_edge, reload;
    logic in_user;

    // ==========================================================
    // pin synchronisers; only the second stage feeds logic
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync1_q <= 6'h3F;
            sync2_q <= 6'h3F;
        end
        else
        begin
            sync1_q <= {reconfig_pin_b_i, config_error_line_low_i, scheme_parallel_i,
                        upgrade_shift_clock_i, shift_din_i, shift_mode_i};
            sync2_q <= sync1_q;
        end
    end

    // edge history for the shift clock and the reconfig pin
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            shclk_prev_q <= 1'b1;
            rcfg_prev_q <= 1'b1;
        end
        else
        begin
            shclk_prev_q <= sync2_q[2];
            rcfg_prev_q <= sync2_q[5];
        end
    end

    // the shift clock is sampled, so it must stay well below half the reference rate
    assign shift_edge = sync2_q[2] && !shclk_prev_q;
    assign pin_rcfg = !sync2_q[5] && rcfg_prev_q;
    assign fabric_rcfg = wr_i && addr_i == REG_CMD && wdata_i[CMD_RECONFIG_BIT];
    assign wd_kick = wr_i && addr_i == REG_CMD && wdata_i[CMD_KICK_BIT];
    assign in_user = state_q == ST_USER_FACTORY || state_q == ST_USER_APP;

    // cause of a reconfiguration; fabric request merges with the pin
    always_comb
    begin
        cause = '0;
        cause.from_app = state_q == ST_LOAD_APP || state_q == ST_USER_APP;
        cause.err_line = sync2_q[4];
        cause.crc = crc_err_i && (in_user || load_done_i);
        cause.wdog = wd_expired && state_q == ST_USER_APP;
        cause.reconfig = in_user && (pin_rcfg || fabric_rcfg);
    end
    assign reload = state_q != ST_RESET && state_q != ST_LOAD_FACTORY
                    && (cause.err_line || cause.crc || cause.wdog || cause.reconfig);

    // ==========================================================
    // oscillator-rate tick that paces the watchdog
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            osc_cnt_q <= 3'h0;
            osc_tick_q <= 1'b0;
        end
        else
        begin
            osc_tick_q <= osc_cnt_q == 3'(OSC_DIV - 1);
            osc_cnt_q <= (osc_cnt_q == 3'(OSC_DIV - 1)) ? 3'h0 : osc_cnt_q + 3'h1;
        end
    end

    ru_watchdog #(
        .CNT_W(WD_CNT_W)
    ) u_watchdog (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .tick_i(osc_tick_q),
        .run_i(state_q == ST_USER_APP && ctrl_q.wd_en),
        .kick_i(wd_kick),
        .reload_i({ctrl_q.wd_timer, WD_LOW_BITS}),
        .expired_o(wd_expired)
    );

    // ==========================================================
    // factory boot address; only the parallel scheme lets it move
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            factory_addr_q <= FACTORY_ADDR_PARALLEL;
        end
        else if (set_factory_boot_address_instr_i && parallel_q)
        begin
            factory_addr_q <= scan_boot_addr_i;
        end
    end

    // ==========================================================
    // sequencer: the strap settles through the synchroniser before it is caught
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q <= ST_RESET;
            wait_q <= 2'h0;
            parallel_q <= 1'b0;
            ctrl_q <= CTRL_RESET;
            status_q <= '0;
        end
        else
        begin
            unique case (state_q)
                ST_RESET:
                begin
                    wait_q <= wait_q + 2'h1;
                    parallel_q <= sync2_q[3];
                    if (wait_q == 2'(STRAP_WAIT - 1))
                    begin
                        state_q <= ST_LOAD_FACTORY;
                    end
                end
                ST_LOAD_FACTORY:
                begin
                    // a failed factory load has nothing to fall back to but itself
                    if (load_done_i && !crc_err_i)
                    begin
                        state_q <= ST_USER_FACTORY;
                    end
                    else if (load_done_i || cause.err_line)
                    begin
                        status_q <= cause;
                    end
                end
                ST_USER_FACTORY:
                begin
                    if (reload)
                    begin
                        status_q <= cause;
                        if (cause.reconfig)
                        begin
                            ctrl_q <= upd_q;
                            state_q <= ST_LOAD_APP;
                        end
                        else
                        begin
                            state_q <= ST_LOAD_FACTORY;
                        end
                    end
                end
                ST_LOAD_APP:
                begin
                    if (reload)
                    begin
                        status_q <= cause;
                        state_q <= ST_LOAD_FACTORY;
                    end
                    else if (load_done_i)
                    begin
                        state_q <= ST_USER_APP;
                    end
                end
                ST_USER_APP:
                begin
                    if (reload)
                    begin
                        status_q <= cause;
                        state_q <= ST_LOAD_FACTORY;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // shift register on the sampled shift clock; factory alone may update
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            shift_q <= '0;
            upd_q <= CTRL_RESET;
        end
        else if (shift_edge && sync2_q[0])
        begin
            shift_q <= {sync2_q[1], shift_q[SHIFT_W-1:1]};
        end
        else if (shift_edge)
        begin
            shift_q <= (state_q == ST_USER_APP) ? ctrl_q : upd_q;
        end
        else if (state_q == ST_USER_FACTORY && shift_update_i)
        begin
            upd_q <= shift_q;
        end
        else if (state_q == ST_USER_FACTORY && wr_i && addr_i == REG_UPD_ADDR)
        begin
            upd_q.ru_addr <= wdata_i[BOOT_W-1:2];
        end
        else if (state_q == ST_USER_FACTORY && wr_i && addr_i == REG_UPD_WD)
        begin
            upd_q.wd_en <= wdata_i[WD_EN_BIT];
            upd_q.wd_timer <= wdata_i[WD_TIMER_W-1:0];
        end
    end

    // ==========================================================
    // outputs and read data, all registered
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            load_req_o <= 1'b0;
            boot_addr_o <= FACTORY_ADDR_SERIAL;
            user_mode_o <= 1'b0;
            app_mode_o <= 1'b0;
            shift_dout_o <= 1'b0;
        end
        else
        begin
            load_req_o <= state_q == ST_LOAD_FACTORY || state_q == ST_LOAD_APP;
            boot_addr_o <= (state_q == ST_LOAD_APP) ? {ctrl_q.ru_addr, 2'b00}
                         : (parallel_q ? factory_addr_q : FACTORY_ADDR_SERIAL);
            user_mode_o <= in_user;
            app_mode_o <= state_q == ST_USER_APP;
            shift_dout_o <= shift_q[0];
        end
    end

    // read data stand for one cycle only, zero otherwise
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rdata_o <= '0;
        end
        else if (!rd_i)
        begin
            rdata_o <= '0;
        end
        else
        begin
            unique case (addr_i)
                REG_CTRL_ADDR: rdata_o <= DATA_W'({ctrl_q.ru_addr, 2'b00});
                REG_CTRL_WD: rdata_o <= DATA_W'({ctrl_q.wd_en, ctrl_q.wd_timer});
                REG_UPD_ADDR: rdata_o <= DATA_W'({upd_q.ru_addr, 2'b00});
                REG_UPD_WD: rdata_o <= DATA_W'({upd_q.wd_en, upd_q.wd_timer});
                REG_STATUS: rdata_o <= DATA_W'(status_q);
                REG_FACT_ADDR: rdata_o <= DATA_W'(factory_addr_q);
                REG_STATE: rdata_o <= DATA_W'(state_q);
                default: rdata_o <= '0;
            endcase
        end
    end

    // ==========================================================
    // checks
    a_factory_boot_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state_q == ST_LOAD_FACTORY && !parallel_q |=> boot_addr_o == FACTORY_ADDR_SERIAL)
        else $error("serial factory load not at address zero");
    a_parallel_default: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(rst_b_i) |-> factory_addr_q == FACTORY_ADDR_PARALLEL)
        else $error("parallel factory address not at default");
    a_scan_boot_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        set_factory_boot_address_instr_i && parallel_q |=> factory_addr_q == $past(scan_boot_addr_i))
        else $error("scan instruction did not move factory address");
    a_error_to_factory: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state_q == ST_USER_APP && (cause.crc || cause.wdog || cause.err_line)
        |=> state_q == ST_LOAD_FACTORY ##1 load_req_o && !app_mode_o)
        else $error("application error did not reload factory");
    a_status_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        reload |=> status_q == $past(cause))
        else $error("status not written with reconfiguration cause");
    a_update_copy: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state_q == ST_USER_FACTORY && cause.reconfig |=> ctrl_q == $past(upd_q))
        else $error("update not copied into control");
    a_user_entry: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state_q == ST_LOAD_APP && load_done_i && !reload |=> ##1 user_mode_o && app_mode_o)
        else $error("clean application load did not reach user mode");
    a_fabric_like_pin: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state_q == ST_USER_APP && fabric_rcfg |=> status_q.reconfig && state_q == ST_LOAD_FACTORY)
        else $error("fabric reconfig not handled like pin");
    a_app_write_lock: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state_q != ST_USER_FACTORY |=> upd_q == $past(upd_q))
        else $error("update register changed outside factory image");

endmodule

/* File: hdl/ru_seq_pkg.sv */
// shared constants, register map, carriers and states of the image sequencer
// assumes a single 50 MHz reference clock drives every user of this package
package ru_seq_pkg;

    // ==========================================================
    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] REG_CTRL_ADDR = 4'h0; // live boot address, read only
    localparam logic [3:0] REG_CTRL_WD = 4'h1; // live watchdog settings, read only
    localparam logic [3:0] REG_UPD_ADDR = 4'h2; // staged boot address
    localparam logic [3:0] REG_UPD_WD = 4'h3; // staged watchdog settings
    localparam logic [3:0] REG_STATUS = 4'h4; // reconfiguration cause record
    localparam logic [3:0] REG_CMD = 4'h5; // write-only command pulses
    localparam logic [3:0] REG_FACT_ADDR = 4'h6; // factory boot address
    localparam logic [3:0] REG_STATE = 4'h7; // sequencer state
    localparam int CMD_RECONFIG_BIT = 0;
    localparam int CMD_KICK_BIT = 1;
    localparam int WD_EN_BIT = 12;

    // ==========================================================
    // image addressing and watchdog layout
    localparam int BOOT_W = 24;
    localparam int RU_ADDR_W = 22;
    localparam int WD_TIMER_W = 12;
    localparam int WD_CNT_W = 29;
    localparam logic [16:0] WD_LOW_BITS = 17'h00008;
    localparam logic [23:0] FACTORY_ADDR_SERIAL = 24'h000000;
    localparam logic [23:0] FACTORY_ADDR_PARALLEL = 24'h010000;

    // ==========================================================
    // timing
    localparam int REF_CLK_HZ = 50000000;
    localparam int OSC_HZ = 10000000;
    localparam int OSC_DIV = REF_CLK_HZ / OSC_HZ;
    localparam int SHIFT_CLK_MAX_HZ = 40000000;
    localparam int STRAP_WAIT = 3;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic wd_en;
        logic [WD_TIMER_W-1:0] wd_timer;
        logic [RU_ADDR_W-1:0] ru_addr;
    } ctrl_s;
    localparam int SHIFT_W = $bits(ctrl_s);
    localparam ctrl_s CTRL_RESET = '{wd_en: 1'b1, wd_timer: 12'h000, ru_addr: 22'h000000};

    typedef struct packed {
        logic from_app;
        logic wdog;
        logic crc;
        logic err_line;
        logic reconfig;
    } status_s;

    typedef enum logic [4:0] {
        ST_RESET = 5'h01,
        ST_LOAD_FACTORY = 5'h02,
        ST_USER_FACTORY = 5'h04,
        ST_LOAD_APP = 5'h08,
        ST_USER_APP = 5'h10
    } seq_state_e;

endpackage

/* File: hdl/ru_watchdog.sv */
// user watchdog of the running application image
// assumes tick_i is a one-cycle enable at the oscillator rate
`timescale 1ns/100ps
module ru_watchdog
    import ru_seq_pkg::*;
#(
    parameter int CNT_W = WD_CNT_W
)
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // control
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic kick_i,
    input wire logic [CNT_W-1:0] reload_i,
    // result
    output logic expired_o
);

    logic [CNT_W-1:0] cnt_q;

    // ==========================================================
    // down counter, reloaded while idle or kicked so each image starts full
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q <= '0;
        end
        else if (!run_i || kick_i)
        begin
            cnt_q <= reload_i;
        end
        else if (tick_i && cnt_q != '0)
        begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // one pulse when the count runs out with the dog armed
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            expired_o <= 1'b0;
        end
        else
        begin
            expired_o <= run_i && !kick_i && tick_i && cnt_q == '0 && !expired_o;
        end
    end

    a_expire_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        expired_o |-> $past(run_i) && $past(cnt_q) == '0)
        else $error("watchdog expired without an armed empty count");

endmodule
